// ### async_serial_pkg.sv
// Package: register map, field positions and types for the serial transmitter
package async_serial_pkg;

  localparam logic [7:0] DATA_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CTRL_ADDR   = 8'h08;
  localparam logic [7:0] BAUD_ADDR   = 8'h0c;
  localparam logic [7:0] PORT_ADDR   = 8'h10;

  // Control register fields
  localparam int CTRL_TE   = 0;
  localparam int CTRL_M    = 1;
  localparam int CTRL_PE   = 2;
  localparam int CTRL_PT   = 3;
  localparam int CTRL_SBK  = 4;
  localparam int CTRL_OPEN_DRAIN_SELECT = 5;

  // Status register fields
  localparam int STAT_TC    = 7;
  localparam int STAT_EMPTY = 8;

  // Port register fields
  localparam int PORT_LATCH = 0;
  localparam int PORT_DIR   = 1;

  localparam int          DATA_W        = 9;
  localparam int          BAUD_W        = 16;
  localparam logic [15:0] BAUD_RESET    = 16'h00d9;
  localparam logic [3:0]  FRAME_BITS_8  = 4'ha;
  localparam logic [3:0]  FRAME_BITS_9  = 4'hb;

  typedef struct packed {
    logic open_drain_select;
    logic send_break_bit;
    logic parity_odd;
    logic pe;
    logic m;
    logic te;
  } ctrl_t;

  typedef struct packed {
    logic dout;
    logic oe;
  } pin_t;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_DATA     = 5'b00010,
    ST_PREAMBLE = 5'b00100,
    ST_BREAK    = 5'b01000,
    ST_MARK     = 5'b10000
  } tx_state_t;

endpackage

// ### async_serial_tx.sv
// Asynchronous serial transmitter with APB register slave
//
// What this block does
// - One data address: reads give received data, writes load transmit data.
// - Bit 8 is the ninth data bit in nine-bit mode, ignored otherwise.
// - A write reaching the low data byte after a status read showing empty starts a transmission.
// - Bits 7:0 hold the first eight data bits both ways.
// - Holding register accepts a character while the shifter is busy.
// - Shifter drives the line while enabled or until sending completes.
// - Frame is start low, data LSB first, stop high; 10 or 11 bits.
// - Enabling with shifter empty sends an all-ones preamble, else after word.
// - Disabling waits for shifter, preamble and break, then sets complete.
// - Disable then re-enable mid-word queues a preamble after that word.
// - After a preamble with no data the line stays marking high.
// - Write while not empty replaces pending data; when empty clears flag.
// - Shifter done with data pending: load it, set holding-empty flag.
// - Ninth bit appended in nine-bit mode; parity replaces last data bit.
// - With nothing left to send, set complete flag and hold line high.
// - Send-break sends whole zero frames after current char, until cleared.
// - At least one bit-time of mark follows a break.
// - Open-drain select applies when transmitting and as a port pin.
// - Disable while complete returns the pin to port control by the next bit-time tick.
// - Holding-empty set by reset; cleared by status read then data write.
// - Complete flag resets to one; cleared by status read then data write.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module async_serial_tx #(
  parameter int BAUD_W = async_serial_pkg::BAUD_W
) (
  input  wire logic        clk_sys,   // System clock, 25 MHz
  input  wire logic        rstn,      // Asynchronous reset, active low
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB enable
  input  wire logic        pwrite,    // APB direction
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  input  wire logic [3:0]  pstrb,     // APB byte strobes
  output logic      [31:0] prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error
  input  wire logic [8:0]  rx_data,   // Received character from receiver
  output logic             txd_out,   // Transmit pin output level
  output logic             txd_oe     // Transmit pin output enable
);

  logic        rst_s1_r;
  logic        rst_s2_r;
  async_serial_pkg::ctrl_t ctrl_r;
  logic [BAUD_W-1:0] baud_div_r;
  logic [BAUD_W-1:0] baud_cnt_r;
  logic        baud_tick;
  logic        port_latch_r;
  logic        port_dir_r;
  logic [8:0]  hold_r;
  logic        empty_r;
  logic        tc_r;
  logic        empty_armed_r;
  logic        tc_armed_r;
  logic        preamble_q_r;
  logic        te_prev_r;
  logic [10:0] shift_r;
  logic [3:0]  bit_cnt_r;
  logic        line_r;
  async_serial_pkg::tx_state_t state_r;
  logic        active;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        data_wr;
  logic        stat_rd;
  logic        load_now;
  logic        frame_end;
  logic [3:0]  frame_len;
  logic [10:0] frame_word;
  logic        par_bit;
  logic [31:0] rd_mux;
  logic        hit;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // APB decode; every access answers in its first access cycle
  assign acc     = psel && penable;
  assign wr_acc  = acc && pwrite;
  assign rd_acc  = acc && !pwrite;
  assign data_wr = wr_acc && paddr == async_serial_pkg::DATA_ADDR
                   && pstrb[0];
  assign stat_rd = rd_acc && paddr == async_serial_pkg::STATUS_ADDR;
  assign hit     = paddr == async_serial_pkg::DATA_ADDR
                   || paddr == async_serial_pkg::STATUS_ADDR
                   || paddr == async_serial_pkg::CTRL_ADDR
                   || paddr == async_serial_pkg::BAUD_ADDR
                   || paddr == async_serial_pkg::PORT_ADDR;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      async_serial_pkg::DATA_ADDR:   rd_mux[8:0] = rx_data;
      async_serial_pkg::STATUS_ADDR: begin
        rd_mux[async_serial_pkg::STAT_TC]    = tc_r;
        rd_mux[async_serial_pkg::STAT_EMPTY] = empty_r;
      end
      async_serial_pkg::CTRL_ADDR:   rd_mux[5:0] = ctrl_r;
      async_serial_pkg::BAUD_ADDR:   rd_mux[BAUD_W-1:0] = baud_div_r;
      async_serial_pkg::PORT_ADDR:   begin
        rd_mux[async_serial_pkg::PORT_LATCH] = port_latch_r;
        rd_mux[async_serial_pkg::PORT_DIR]   = port_dir_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Control, baud divisor and port registers
  always_ff @(posedge clk_sys or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      ctrl_r       <= '0;
      baud_div_r   <= async_serial_pkg::BAUD_RESET[BAUD_W-1:0];
      port_latch_r <= 1'b1;
      port_dir_r   <= 1'b0;
    end else if (wr_acc && pready) begin
      if (paddr == async_serial_pkg::CTRL_ADDR && pstrb[0])
        ctrl_r <= pwdata[5:0];
      if (paddr == async_serial_pkg::BAUD_ADDR && pstrb[0])
        baud_div_r <= pwdata[BAUD_W-1:0];
      if (paddr == async_serial_pkg::PORT_ADDR && pstrb[0]) begin
        port_latch_r <= pwdata[async_serial_pkg::PORT_LATCH];
        port_dir_r   <= pwdata[async_serial_pkg::PORT_DIR];
      end
    end
  end

  // Bit-time enable from the baud divider
  always_ff @(posedge clk_sys or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      baud_cnt_r <= '0;
    end else if (baud_cnt_r >= baud_div_r) begin
      baud_cnt_r <= '0;
    end else begin
      baud_cnt_r <= baud_cnt_r + 1'b1;
    end
  end
  assign baud_tick = baud_cnt_r >= baud_div_r;

  // Frame assembly
  assign frame_len = ctrl_r.m ? async_serial_pkg::FRAME_BITS_9
                              : async_serial_pkg::FRAME_BITS_8;
  always_comb begin
    par_bit    = ctrl_r.parity_odd;
    frame_word = '1;
    if (ctrl_r.m) begin
      par_bit = par_bit ^ (^hold_r[7:0]);
      frame_word = {1'b1, ctrl_r.pe ? par_bit : hold_r[8],
                    hold_r[7:0], 1'b0};
    end else begin
      par_bit = par_bit ^ (^hold_r[6:0]);
      frame_word = {2'b11, ctrl_r.pe ? par_bit : hold_r[7],
                    hold_r[6:0], 1'b0};
    end
  end

  assign frame_end = baud_tick && bit_cnt_r == frame_len - 4'h1;
  assign active    = state_r != async_serial_pkg::ST_IDLE;
  assign load_now  = !empty_r && ctrl_r.te && !ctrl_r.send_break_bit
                     && !preamble_q_r;

  // Holding register and status flags
  always_ff @(posedge clk_sys or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      hold_r        <= '0;
      empty_r       <= 1'b1;
      tc_r          <= 1'b1;
      empty_armed_r <= 1'b0;
      tc_armed_r    <= 1'b0;
    end else begin
      if (stat_rd && pready) begin
        empty_armed_r <= empty_r;
        tc_armed_r    <= tc_r;
      end
      if (data_wr && pready) begin
        hold_r <= pwdata[8:0];
        if (empty_armed_r) begin
          empty_r       <= 1'b0;
          empty_armed_r <= 1'b0;
        end
        if (tc_armed_r) begin
          tc_r       <= 1'b0;
          tc_armed_r <= 1'b0;
        end
      end
      // Hardware set wins over a same-cycle clear
      if ((state_r == async_serial_pkg::ST_IDLE
           || state_r == async_serial_pkg::ST_MARK
           || (state_r != async_serial_pkg::ST_BREAK && frame_end))
          && load_now && baud_tick)
        empty_r <= 1'b1;
      if (state_r != async_serial_pkg::ST_IDLE && frame_end
          && !load_now && !ctrl_r.te)
        tc_r <= 1'b1;
      if (state_r == async_serial_pkg::ST_MARK && baud_tick
          && !load_now && !preamble_q_r)
        tc_r <= 1'b1;
    end
  end

  // Preamble queue on enable rising edge, or re-enable mid-word
  always_ff @(posedge clk_sys or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      te_prev_r    <= 1'b0;
      preamble_q_r <= 1'b0;
    end else begin
      te_prev_r <= ctrl_r.te;
      if (ctrl_r.te && !te_prev_r)
        preamble_q_r <= 1'b1;
      else if (state_r == async_serial_pkg::ST_PREAMBLE)
        preamble_q_r <= 1'b0;
    end
  end

  // Transmit sequencer
  always_ff @(posedge clk_sys or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r   <= async_serial_pkg::ST_IDLE;
      shift_r   <= '1;
      bit_cnt_r <= '0;
      line_r    <= 1'b1;
    end else if (baud_tick) begin
      unique case (state_r)
        async_serial_pkg::ST_IDLE, async_serial_pkg::ST_MARK: begin
          line_r    <= 1'b1;
          bit_cnt_r <= '0;
          if (ctrl_r.te && ctrl_r.send_break_bit) begin
            state_r <= async_serial_pkg::ST_BREAK;
            line_r  <= 1'b0;
          end else if (preamble_q_r && ctrl_r.te) begin
            state_r <= async_serial_pkg::ST_PREAMBLE;
          end else if (load_now) begin
            state_r <= async_serial_pkg::ST_DATA;
            shift_r <= frame_word >> 1;
            line_r  <= frame_word[0];
          end else if (!ctrl_r.te) begin
            state_r <= async_serial_pkg::ST_IDLE;
          end
        end
        default: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (state_r == async_serial_pkg::ST_DATA) begin
            line_r  <= shift_r[0];
            shift_r <= {1'b1, shift_r[10:1]};
          end
          if (frame_end) begin
            bit_cnt_r <= '0;
            line_r    <= 1'b1;
            if (ctrl_r.te && ctrl_r.send_break_bit) begin
              state_r <= async_serial_pkg::ST_BREAK;
              line_r  <= 1'b0;
            end else if (state_r == async_serial_pkg::ST_BREAK) begin
              state_r <= async_serial_pkg::ST_MARK;
            end else if (ctrl_r.te && preamble_q_r) begin
              state_r <= async_serial_pkg::ST_PREAMBLE;
            end else if (load_now) begin
              state_r <= async_serial_pkg::ST_DATA;
              shift_r <= frame_word >> 1;
              line_r  <= frame_word[0];
            end else if (ctrl_r.te) begin
              state_r <= async_serial_pkg::ST_MARK;
            end else begin
              state_r <= async_serial_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Pin mux: transmitter or port, push-pull or open drain
  always_ff @(posedge clk_sys or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      txd_out <= 1'b1;
      txd_oe  <= 1'b0;
    end else if (ctrl_r.te || active) begin
      txd_out <= line_r;
      txd_oe  <= ctrl_r.open_drain_select ? !line_r : 1'b1;
    end else begin
      txd_out <= port_latch_r;
      txd_oe  <= port_dir_r && (!ctrl_r.open_drain_select || !port_latch_r);
    end
  end

endmodule // async_serial_tx

`default_nettype wire

// ### async_serial_tx_monitor.sv
// Assertion checker bound to the serial transmitter
`timescale 1ns/10ps
`default_nettype none
module async_serial_tx_monitor #(
  parameter int BAUD_W = async_serial_pkg::BAUD_W
) (
  input wire logic        clk_sys, // Clock
  input wire logic        rstn,    // Reset
  input wire logic        psel,    // Select
  input wire logic        penable, // Enable
  input wire logic        pwrite,  // Direction
  input wire logic [7:0]  paddr,   // Address
  input wire logic [31:0] pwdata,  // Write data
  input wire logic [3:0]  pstrb,   // Strobes
  input wire logic [31:0] prdata,  // Read data
  input wire logic        pready,  // Ready
  input wire logic        pslverr, // Error
  input wire logic [8:0]  rx_data, // Received character
  input wire logic        txd_out, // Pin level
  input wire logic        txd_oe   // Pin enable
);
  logic [BAUD_W-1:0]       baud_r;
  async_serial_pkg::ctrl_t ctrl_r;
  logic [7:0]              gap_r;
  logic                    last_r;
  logic                    wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
  // Shadow of the settings the line timing depends on
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      baud_r <= async_serial_pkg::BAUD_RESET[BAUD_W-1:0];
      ctrl_r <= '0;
    end else if (wr_ok && paddr == async_serial_pkg::BAUD_ADDR) begin
      baud_r <= pwdata[BAUD_W-1:0];
    end else if (wr_ok && paddr == async_serial_pkg::CTRL_ADDR) begin
      ctrl_r <= pwdata[5:0];
    end
  end
  // Cycles the pin level has held
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gap_r  <= 8'h00;
      last_r <= 1'b1;
    end else begin
      last_r <= txd_out;
      gap_r  <= (txd_out != last_r) ? 8'h01 : gap_r + {7'h0, gap_r != 8'hff};
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside one access cycle");
  a_err_unmapped: assert property (
    pready && paddr > async_serial_pkg::PORT_ADDR |-> pslverr)
    else $error("unmapped access not refused");
  a_err_cause: assert property (
    pslverr |-> pready && (paddr > async_serial_pkg::PORT_ADDR || paddr[1:0] != 2'b00))
    else $error("error on mapped access");
  a_read_data: assert property (
    pready && !pwrite && paddr == async_serial_pkg::DATA_ADDR
    |-> prdata[7:0] == rx_data[7:0] && prdata[31:9] == 23'h0)
    else $error("data read wrong");
  a_bit_spacing: assert property (
    txd_oe && $past(txd_oe) && !txd_out && last_r |-> gap_r > 8'(baud_r))
    else $error("line fell before a bit-time passed");
  a_open_drain: assert property (
    ctrl_r.open_drain_select && $past(ctrl_r.open_drain_select) |-> !(txd_oe && txd_out))
    else $error("open drain drove high");
  a_drive_enabled: assert property (
    ctrl_r.te && $past(ctrl_r.te, 2) && !ctrl_r.open_drain_select && !$past(ctrl_r.open_drain_select, 2)
    |-> txd_oe) else $error("pin not driven while enabled");
endmodule // async_serial_tx_monitor
bind async_serial_tx async_serial_tx_monitor #(.BAUD_W(BAUD_W)) mon_u (
  .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_data(rx_data),
  .txd_out(txd_out), .txd_oe(txd_oe));
`default_nettype wire

// ### async_rx_model.sv
// Far-end serial receiver model watching the transmit line
`timescale 1ns/10ps
`default_nettype none
module async_rx_model (
  input  wire logic       clk_sys, // Clock
  input  wire logic       line,    // Wire level of the line
  input  wire logic [3:0] bits,    // Data bits per frame
  input  wire logic [7:0] bt,      // Clocks per bit-time
  output logic      [8:0] word,    // Last data bits
  output logic            stop,    // Last stop level
  output int              nfr      // Frames seen
);
  int i;
  // Samples at mid-bit, so an idle preamble without a fall is never a frame
  initial begin
    nfr  = 0;
    word = 9'h000;
    stop = 1'b0;
    forever begin
      @(negedge line);
      repeat (bt / 2) @(posedge clk_sys);
      if (line === 1'b0) begin
        word = 9'h000;
        for (i = 0; i < bits; i++) begin
          repeat (bt) @(posedge clk_sys);
          word[i] = line;
        end
        repeat (bt) @(posedge clk_sys);
        stop = line;
        nfr++;
      end
    end
  end
endmodule // async_rx_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the serial transmitter
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk_sys = 1'b0;
  logic        rstn, psel, penable, pwrite, pready, pslverr, er, stop;
  logic        txd_out, txd_oe, line;
  logic [7:0]  paddr, bt;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb, bits;
  logic [8:0]  rx_data, word, d, x;
  logic [3:0]  md [4] = '{4'h1, 4'h3, 4'h5, 4'hf};
  int          seed = 32'h704b8dce;
  int          nfr, n_fail, num_checks, k;
  // Pull-up holds the line high when nobody drives it
  assign line = txd_oe ? txd_out : 1'b1;
  always #20 clk_sys = ~clk_sys;
  async_serial_tx dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_data(rx_data), .txd_out(txd_out), .txd_oe(txd_oe));
  async_rx_model rx_u (.clk_sys(clk_sys), .line(line), .bits(bits),
    .bt(bt), .word(word), .stop(stop), .nfr(nfr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int t = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 20);
    q  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1);
  endtask
  task automatic send(input logic [8:0] v);
    apb(1'b0, async_serial_pkg::STATUS_ADDR, 32'h0);
    apb(1'b1, async_serial_pkg::DATA_ADDR, {23'h0, v});
  endtask
  task automatic poll(input int b);
    int t = 0;
    do begin
      apb(1'b0, async_serial_pkg::STATUS_ADDR, 32'h0);
      t++;
    end while (q[b] !== 1'b1 && t < 100);
    chk({31'h0, q[b]}, 32'h1);
  endtask
  task automatic frame(input logic [8:0] v, input logic s);
    int n = nfr;
    int t = 0;
    while (nfr == n && t < 300) begin
      @(posedge clk_sys);
      t++;
    end
    chk({22'h0, stop, word}, {22'h0, s, v});
  endtask
  // Bits seen on the line for a control setting {odd, parity, nine, enable}
  function automatic logic [8:0] expw(input logic [3:0] c,
                                      input logic [8:0] v);
    logic [8:0] r;
    r = c[1] ? v : {1'b0, v[7:0]};
    if (c[2] && c[1]) r[8] = ^v[7:0] ^ c[3];
    if (c[2] && !c[1]) r[7] = ^v[6:0] ^ c[3];
    return r;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb   = 4'hf;
    rx_data = 9'h000;
    bits    = 4'h8;
    bt      = 8'h04;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, async_serial_pkg::STATUS_ADDR, 32'h0);
    chk(q & 32'h180, 32'h180);
    rx_data <= 9'($random(seed));
    apb(1'b0, async_serial_pkg::DATA_ADDR, 32'h0);
    chk({23'h0, q[8:0]}, {23'h0, rx_data});
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, async_serial_pkg::BAUD_ADDR, 32'h3);
    for (k = 0; k < 4; k++) begin
      bits = md[k][1] ? 4'h9 : 4'h8;
      apb(1'b1, async_serial_pkg::CTRL_ADDR, {28'h0, md[k]});
      d = 9'($random(seed));
      send(d);
      if (k == 0) begin
        repeat (30) @(posedge clk_sys);
        chk({31'h0, line}, 32'h1);
      end
      poll(async_serial_pkg::STAT_EMPTY);
      send(9'($random(seed)));
      x = 9'($random(seed));
      send(x);
      frame(expw(md[k], d), 1'b1);
      frame(expw(md[k], x), 1'b1);
      poll(async_serial_pkg::STAT_TC);
    end
    bits = 4'h8;
    apb(1'b1, async_serial_pkg::CTRL_ADDR, 32'h11);
    frame(9'h000, 1'b0);
    apb(1'b1, async_serial_pkg::CTRL_ADDR, 32'h1);
    d = 9'($random(seed));
    send(d);
    poll(async_serial_pkg::STAT_EMPTY);
    apb(1'b1, async_serial_pkg::CTRL_ADDR, 32'h0);
    frame(expw(4'h1, d), 1'b1);
    poll(async_serial_pkg::STAT_TC);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, txd_oe}, 32'h0);
    apb(1'b1, async_serial_pkg::PORT_ADDR, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk({30'h0, txd_oe, txd_out}, 32'h2);
    apb(1'b1, async_serial_pkg::CTRL_ADDR, 32'h20);
    apb(1'b1, async_serial_pkg::PORT_ADDR, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, txd_oe}, 32'h0);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
endmodule // testbench
`default_nettype wire
